// ===== bench/reset_clock_source.sv
// Purpose: Far side model: reset pin, crystal input and internal RC clock
// Assumes: Pin has an external pull-up; both oscillators free-run
// Notes:   Half periods in clk cycles set how slow each clock runs
`timescale 1ns/10ps
module reset_clock_source #(
  parameter int RC_HALF  = 2,
  parameter int OSC_HALF = 3
) (
  input  wire logic clk,
  input  wire logic pin_low_req,
  output logic      ext_reset_n,
  output logic      osc_input_pin,
  output logic      rc_osc_clk
);
  int rc_cnt  = 0;
  int osc_cnt = 0;
  // Pull-up brings the pin high again as soon as nobody pulls it
  assign ext_reset_n = !pin_low_req;
  initial begin
    rc_osc_clk    = 1'b0;
    osc_input_pin = 1'b0;
  end
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
    if (rc_cnt == RC_HALF - 1) rc_osc_clk <= !rc_osc_clk;
  end
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1) osc_input_pin <= !osc_input_pin;
  end
endmodule : reset_clock_source

// ===== bench/reset_startup_sequencer_tb.sv
// Purpose: Self-checking bench for the reset and start-up sequencer
// Assumes: Crystal mode 1, power-up timer on, brown-out detection on
// Notes:   Start-up waits are bounded loops, never fixed delays
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
  end end
module reset_startup_sequencer_tb;
  // RC ticks span 4 clk, crystal cycles 6 clk in the partner model
  localparam int PWR = rst_seq_pkg::POWERUP_RC_TICKS * 4;
  localparam int OSC_STARTUP_COUNTER = rst_seq_pkg::STARTUP_OSC_CYCLES * 6;
  logic       clk = 1'b0, rst_b, por, vlow, pin_low, wdog, slp, pin_cfg;
  logic       gpo, goe, wr, rd, ext_n, osc, rc, p, q, pwd, ben;
  logic       chip_reset, stall, wake, cqo, sio, soe;
  logic [2:0] mode;
  logic [7:0] addr, wdata, rdata, trim, d;
  int         fail_count = 0, checks_done = 0, cycles = 0, n, hi, wk, st;

  always #5 clk = !clk;
  reset_clock_source reset_clock_source_inst (.clk(clk),
    .pin_low_req(pin_low), .ext_reset_n(ext_n), .osc_input_pin(osc),
    .rc_osc_clk(rc));
  reset_startup_sequencer reset_startup_sequencer_inst (.clk(clk),
    .clk_en(1'b1), .rst_b(rst_b), .por_active(por),
    .vdd_below_brownout(vlow), .ext_reset_n(ext_n), .osc_input_pin(osc),
    .rc_osc_clk(rc), .watchdog_timeout(wdog), .sleeping(slp),
    .osc_mode_cfg(mode), .powerup_timer_disable_cfg(pwd),
    .brownout_enable_cfg(ben), .ext_reset_pin_cfg(pin_cfg),
    .gpio_out(gpo), .gpio_oe(goe), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .chip_reset(chip_reset), .cpu_stall(stall),
    .watchdog_wakeup(wake), .osc_trim(trim), .clock_quarter_out(cqo),
    .shared_io_out(sio), .shared_io_oe(soe));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Hang guard: whole run needs about 23000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  // Read data is taken at the following edge, before it returns to 0
  task automatic rd_reg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic cause_is(input rst_seq_pkg::cause_t c);
    rd_reg(rst_seq_pkg::ADDR_CAUSE);
    `CHK(d, {5'h00, c})
  endtask : cause_is
  task automatic wait_run(input int lim);
    n = 0;
    while ((chip_reset | stall) !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_run
  task automatic pin_pulse(input int len);
    pin_low <= 1'b1;
    hi = 0;
    repeat (len) begin
      @(posedge clk);
      hi += (chip_reset === 1'b1);
    end
    pin_low <= 1'b0;
    // Let the pin stand high so back-to-back pulses stay apart
    repeat (4) @(posedge clk);
  endtask : pin_pulse
  task automatic wd_pulse(input logic s);
    slp <= s;
    @(posedge clk);
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    hi = 0;
    wk = 0;
    st = 0;
    repeat (12) begin
      @(posedge clk);
      hi += (chip_reset === 1'b1);
      wk += (wake === 1'b1);
      st += (stall === 1'b1);
    end
  endtask : wd_pulse
  task automatic dip(input int len);
    vlow <= 1'b1;
    repeat (len) @(posedge clk);
    vlow <= 1'b0;
  endtask : dip

  initial begin
    rst_b = 0; por = 1; vlow = 0; pin_low = 0; wdog = 0; slp = 0;
    pin_cfg = 0; gpo = 0; goe = 0; wr = 0; rd = 0; mode = 3'h1;
    addr = 8'h00;
    pwd = 0;
    ben = 1;
    wdata = 8'h00;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(chip_reset, 1'b1)
    `CHK(trim, rst_seq_pkg::TRIM_RST)
    por <= 1'b0;
    wait_run(30000);
    `CHK(n > PWR + OSC_STARTUP_COUNTER - 20 && n < PWR + OSC_STARTUP_COUNTER + 100, 1'b1)
    `CHK(soe, 1'b0)
    rd_reg(rst_seq_pkg::ADDR_FLAGS);
    `CHK(d[1], 1'b0)
    wr_reg(rst_seq_pkg::ADDR_FLAGS, 8'hff);
    wr_reg(rst_seq_pkg::ADDR_TRIM, 8'ha5);
    wr_reg(rst_seq_pkg::ADDR_KEEP, 8'h3c);
    wr_reg(rst_seq_pkg::ADDR_CAUSE, 8'h07);
    `CHK(trim, 8'ha5)
    rd_reg(rst_seq_pkg::ADDR_FLAGS);
    `CHK(d, 8'h03)
    cause_is(rst_seq_pkg::CAUSE_POR);
    rd_reg(8'h55);
    `CHK(d, 8'h00)
    pin_pulse(50);
    `CHK(hi, 0)
    pin_pulse(300);
    `CHK(hi > 0, 1'b1)
    wait_run(20);
    `CHK(n < 10, 1'b1)
    cause_is(rst_seq_pkg::CAUSE_PIN_RUN);
    rd_reg(rst_seq_pkg::ADDR_KEEP);
    `CHK(d, 8'h3c)
    rd_reg(rst_seq_pkg::ADDR_FLAGS);
    `CHK(d, 8'h03)
    pin_cfg <= 1'b1;
    pin_pulse(300);
    `CHK(hi, 0)
    repeat (10) @(posedge clk);
    pin_cfg <= 1'b0;
    slp <= 1'b1;
    pin_pulse(300);
    wait_run(20);
    cause_is(rst_seq_pkg::CAUSE_PIN_SLEEP);
    wd_pulse(1'b0);
    `CHK(hi, 1)
    cause_is(rst_seq_pkg::CAUSE_WATCHDOG_RUN);
    wd_pulse(1'b1);
    `CHK(hi, 0)
    `CHK(wk, 1)
    `CHK(st > 0, 1'b1)
    wait_run(8000);
    slp <= 1'b0;
    cause_is(rst_seq_pkg::CAUSE_WATCHDOG_SLEEP);
    dip(5);
    repeat (8) @(posedge clk);
    `CHK(chip_reset, 1'b0)
    dip(50);
    repeat (1000) @(posedge clk);
    `CHK(chip_reset, 1'b1)
    dip(50);
    wait_run(20000);
    `CHK(n > PWR - 20 && n < PWR + OSC_STARTUP_COUNTER / 2, 1'b1)
    rd_reg(rst_seq_pkg::ADDR_FLAGS);
    `CHK(d, 8'h02)
    cause_is(rst_seq_pkg::CAUSE_BROWNOUT);
    pwd <= 1'b1;
    wr_reg(rst_seq_pkg::ADDR_FLAGS, 8'hff);
    dip(50);
    wait_run(40);
    `CHK(n < 30, 1'b1)
    rd_reg(rst_seq_pkg::ADDR_FLAGS);
    `CHK(d, 8'h02)
    pwd <= 1'b0;
    ben <= 1'b0;
    wr_reg(rst_seq_pkg::ADDR_FLAGS, 8'hff);
    dip(50);
    repeat (4) @(posedge clk);
    `CHK(chip_reset, 1'b0)
    mode <= rst_seq_pkg::INTERNAL_OSC_MODE_CLK;
    repeat (4) @(posedge clk);
    p = sio;
    q = cqo;
    hi = 0;
    st = 0;
    repeat (8) begin
      @(posedge clk);
      hi += (sio !== p);
      st += (cqo !== q);
      p = sio;
      q = cqo;
    end
    `CHK(hi, 4)
    `CHK(st, 4)
    `CHK(soe, 1'b1)
    mode <= rst_seq_pkg::INTERNAL_OSC_MODE_IO;
    gpo <= 1'b1;
    goe <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({sio, soe}, 2'b11)
    test_done();
  end
endmodule : reset_startup_sequencer_tb

// ===== verilog/pulse_filter.sv
// Purpose: Pass a level only after it has stood for N clock cycles
// Assumes: Input already synchronised to clk
// Notes:   Release is immediate; only the asserting edge is delayed
`timescale 1ns/10ps
module pulse_filter #(
  parameter int N = 4
) (
  input  wire logic clk,
  input  wire logic clk_en,
  input  wire logic rst_b,
  input  wire logic level_in,
  output logic      level_out
);

  localparam int         W    = $clog2(N + 1);
  localparam logic [W-1:0] LAST = W'(N - 1);

  logic [W-1:0] cnt_r;
  logic         out_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (clk_en) begin
      if (!level_in) begin
        cnt_r <= '0;
        out_r <= 1'b0;
      end else if (cnt_r == LAST) begin
        out_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  assign level_out = out_r;

  property p_filter_width;
    @(posedge clk) disable iff (!rst_b)
      $rose(out_r) |-> $past(cnt_r) == LAST && $past(level_in);
  endproperty
  a_filter_width: assert property (p_filter_width)
    else $error("filter passed a pulse shorter than its width");

endmodule : pulse_filter

// ===== verilog/reset_startup_sequencer.sv
// Purpose: Reset cause tracking, power-up and start-up time-outs, clock out
// Assumes: Config inputs static; watchdog and sleep come from this clock
// Notes:   Analog monitors, pin and oscillators arrive asynchronously
`timescale 1ns/10ps
// Function
// - RC and internal-oscillator modes put either I/O or clock/4 on shared pin.
// - Oscillator trim register is written by software with the stored literal.
// - Six reset causes are told apart and recorded.
// - Chip reset clears registers except on watchdog wake-up from sleep.
// - One register is never reset and keeps its content through resets.
// - External reset pin is filtered so short glitches are ignored.
// - Watchdog reset acts internally and never drives the reset pin.
// - Internal-reset option ignores the external reset pin entirely.
// - Power-on detector holds reset until supply is good; no reset on fall.
// - Power-up timer holds reset after power-on or brown-out, on RC ticks.
// - Power-up timer disable bit skips it, also after brown-out.
// - Start-up counter waits 1024 crystal cycles after the power-up delay.
// - Start-up count only in crystal modes after power-on or wake-up.
// - Brown-out enabled by config resets on dips longer than the minimum.
// - Power-on and brown-out resets wait for supply above threshold, then the power-up delay.
// - Supply dip during power-up delay restarts it from brown-out.
// - Power-up delay follows the power-on pulse, then start-up count.
// - Time-outs ignore the pin; late pin release starts at once.
// - Flag bit 0 is active-low brown-out flag, set by software.
// - Flag bit 1 is active-low power-on flag, cleared by power-on or a software write of 0.
module reset_startup_sequencer (
  input  wire logic       clk,
  input  wire logic       clk_en,
  input  wire logic       rst_b,
  input  wire logic       por_active,
  input  wire logic       vdd_below_brownout,
  input  wire logic       ext_reset_n,
  input  wire logic       osc_input_pin,
  input  wire logic       rc_osc_clk,
  input  wire logic       watchdog_timeout,
  input  wire logic       sleeping,
  input  wire logic [2:0] osc_mode_cfg,
  input  wire logic       powerup_timer_disable_cfg,
  input  wire logic       brownout_enable_cfg,
  input  wire logic       ext_reset_pin_cfg,
  input  wire logic       gpio_out,
  input  wire logic       gpio_oe,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  output logic            chip_reset,
  output logic            cpu_stall,
  output logic            watchdog_wakeup,
  output logic [7:0]      osc_trim,
  output logic            clock_quarter_out,
  output logic            shared_io_out,
  output logic            shared_io_oe
);

  function automatic logic [rst_seq_pkg::CNT_W:0] count_step(
    input logic [rst_seq_pkg::CNT_W-1:0] cnt,
    input logic                          tick,
    input logic [rst_seq_pkg::CNT_W-1:0] last
  );
    logic done;
    done = tick && (cnt == last);
    if (done)
      count_step = {1'b1, {rst_seq_pkg::CNT_W{1'b0}}};
    else if (tick)
      count_step = {1'b0, cnt + rst_seq_pkg::CNT_W'(1)};
    else
      count_step = {1'b0, cnt};
  endfunction : count_step

  // Two-flop synchronisers; bit order: por, vdd, pin, osc, rc
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [1:0] edge_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_r <= 5'h05;
      sync2_r <= 5'h05;
      edge_r  <= 2'h0;
    end else if (clk_en) begin
      sync1_r <= {rc_osc_clk, osc_input_pin, ext_reset_n,
                  vdd_below_brownout, por_active};
      sync2_r <= sync1_r;
      edge_r  <= sync2_r[4:3];
    end
  end

  logic por_s;
  logic supply_low;
  logic pin_raw_act;
  logic pin_act;
  logic brownout_filt;
  logic brownout_evt;
  logic osc_edge;
  logic rc_edge;
  logic crystal_mode;
  logic clock_quarter_out_mode;

  assign por_s        = sync2_r[0];
  assign supply_low   = brownout_enable_cfg && sync2_r[1];
  assign pin_raw_act  = !sync2_r[2] && !ext_reset_pin_cfg;
  assign osc_edge     = sync2_r[3] && !edge_r[0];
  assign rc_edge      = sync2_r[4] && !edge_r[1];
  assign brownout_evt = brownout_enable_cfg && brownout_filt;
  assign crystal_mode = osc_mode_cfg == rst_seq_pkg::CRYSTAL_LOWPOWER_MODE ||
                        osc_mode_cfg == rst_seq_pkg::CRYSTAL_MID_MODE ||
                        osc_mode_cfg == rst_seq_pkg::CRYSTAL_FAST_MODE;
  assign clock_quarter_out_mode  = osc_mode_cfg == rst_seq_pkg::INTERNAL_OSC_MODE_CLK ||
                        osc_mode_cfg == rst_seq_pkg::RC_MODE_CLK;

  // Glitch filter on the reset pin
  pulse_filter #(.N(rst_seq_pkg::EXT_RESET_FILT_CYC)) u_pin_filter (
    .clk       (clk),
    .clk_en    (clk_en),
    .rst_b     (rst_b),
    .level_in  (pin_raw_act),
    .level_out (pin_act)
  );

  // Short supply dips are dropped before brown-out detection; ST_HOLD and ST_POWERUP still act on the raw supply_low
  pulse_filter #(.N(rst_seq_pkg::BROWNOUT_FILT_CYC)) u_vdd_filter (
    .clk       (clk),
    .clk_en    (clk_en),
    .rst_b     (rst_b),
    .level_in  (supply_low),
    .level_out (brownout_filt)
  );

  rst_seq_pkg::seq_state_t       state_r;
  rst_seq_pkg::seq_state_t       state_nxt;
  rst_seq_pkg::cause_t           cause_r;
  rst_seq_pkg::cause_t           cause_nxt;
  logic [rst_seq_pkg::CNT_W-1:0] cnt_r;
  logic [rst_seq_pkg::CNT_W-1:0] cnt_nxt;
  logic [rst_seq_pkg::CNT_W:0]   step;
  logic                          wake_nxt;
  logic                          wake_r;
  logic                          startup_needed;

  assign startup_needed = crystal_mode &&
                          cause_r == rst_seq_pkg::CAUSE_POR;

  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    cnt_nxt   = cnt_r;
    wake_nxt  = 1'b0;
    step      = '0;
    unique case (state_r)
      rst_seq_pkg::ST_HOLD: begin
        cnt_nxt = '0;
        if (!por_s && !supply_low) begin
          if (!powerup_timer_disable_cfg)
            state_nxt = rst_seq_pkg::ST_POWERUP;
          else if (startup_needed)
            state_nxt = rst_seq_pkg::ST_STARTUP;
          else
            state_nxt = rst_seq_pkg::ST_PIN;
        end
      end
      rst_seq_pkg::ST_POWERUP: begin
        step    = count_step(cnt_r, rc_edge, rst_seq_pkg::POWERUP_LAST);
        cnt_nxt = step[rst_seq_pkg::CNT_W-1:0];
        if (supply_low) begin
          state_nxt = rst_seq_pkg::ST_HOLD;
          cause_nxt = rst_seq_pkg::CAUSE_BROWNOUT;
          cnt_nxt   = '0;
        end else if (step[rst_seq_pkg::CNT_W]) begin
          state_nxt = startup_needed ? rst_seq_pkg::ST_STARTUP
                                     : rst_seq_pkg::ST_PIN;
        end
      end
      rst_seq_pkg::ST_STARTUP: begin
        step    = count_step(cnt_r, osc_edge, rst_seq_pkg::STARTUP_LAST);
        cnt_nxt = step[rst_seq_pkg::CNT_W-1:0];
        if (step[rst_seq_pkg::CNT_W])
          state_nxt = rst_seq_pkg::ST_PIN;
      end
      rst_seq_pkg::ST_PIN: begin
        // Time-outs may already be spent; release runs at once
        if (!pin_act)
          state_nxt = rst_seq_pkg::ST_RUN;
      end
      rst_seq_pkg::ST_WATCHDOG: begin
        // Internal only: the reset pin is an input and is never driven
        state_nxt = rst_seq_pkg::ST_RUN;
      end
      rst_seq_pkg::ST_RUN: begin
        if (pin_act) begin
          state_nxt = rst_seq_pkg::ST_PIN;
          cause_nxt = sleeping ? rst_seq_pkg::CAUSE_PIN_SLEEP
                               : rst_seq_pkg::CAUSE_PIN_RUN;
        end else if (watchdog_timeout && sleeping) begin
          // Wake-up resumes the program; registers stay as they are
          wake_nxt  = 1'b1;
          cause_nxt = rst_seq_pkg::CAUSE_WATCHDOG_SLEEP;
          cnt_nxt   = '0;
          state_nxt = crystal_mode ? rst_seq_pkg::ST_WAKE
                                   : rst_seq_pkg::ST_RUN;
        end else if (watchdog_timeout) begin
          state_nxt = rst_seq_pkg::ST_WATCHDOG;
          cause_nxt = rst_seq_pkg::CAUSE_WATCHDOG_RUN;
        end
      end
      rst_seq_pkg::ST_WAKE: begin
        step    = count_step(cnt_r, osc_edge, rst_seq_pkg::STARTUP_LAST);
        cnt_nxt = step[rst_seq_pkg::CNT_W-1:0];
        if (pin_act) begin
          state_nxt = rst_seq_pkg::ST_PIN;
          cause_nxt = rst_seq_pkg::CAUSE_PIN_SLEEP;
        end else if (step[rst_seq_pkg::CNT_W]) begin
          state_nxt = rst_seq_pkg::ST_RUN;
        end
      end
    endcase
    // Supply events outrank everything else
    if (por_s) begin
      state_nxt = rst_seq_pkg::ST_HOLD;
      cause_nxt = rst_seq_pkg::CAUSE_POR;
      cnt_nxt   = '0;
      wake_nxt  = 1'b0;
    end else if (brownout_evt && state_r != rst_seq_pkg::ST_HOLD) begin
      state_nxt = rst_seq_pkg::ST_HOLD;
      cause_nxt = rst_seq_pkg::CAUSE_BROWNOUT;
      cnt_nxt   = '0;
      wake_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= rst_seq_pkg::ST_HOLD;
      cause_r <= rst_seq_pkg::CAUSE_POR;
      cnt_r   <= '0;
      wake_r  <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      cnt_r   <= cnt_nxt;
      wake_r  <= wake_nxt;
    end
  end

  // Chip reset also serves as the register initialise for the core
  assign chip_reset      = state_r != rst_seq_pkg::ST_RUN &&
                           state_r != rst_seq_pkg::ST_WAKE;
  assign cpu_stall       = state_r == rst_seq_pkg::ST_WAKE;
  assign watchdog_wakeup = wake_r;

  // Clock divider and shared pin
  logic [1:0] div_r;
  logic       pin_out_r;
  logic       pin_oe_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_r     <= 2'h0;
      pin_out_r <= 1'b0;
      pin_oe_r  <= 1'b0;
    end else if (clk_en) begin
      div_r <= div_r + 2'h1;
      if (clock_quarter_out_mode) begin
        pin_out_r <= div_r[1];
        pin_oe_r  <= 1'b1;
      end else if (crystal_mode) begin
        // Pin belongs to the crystal here
        pin_out_r <= 1'b0;
        pin_oe_r  <= 1'b0;
      end else begin
        pin_out_r <= gpio_out;
        pin_oe_r  <= gpio_oe;
      end
    end
  end

  assign clock_quarter_out = div_r[1];
  assign shared_io_out     = pin_out_r;
  assign shared_io_oe      = pin_oe_r;

  // Register port
  logic [7:0] flags_r;
  logic [7:0] trim_r;
  logic [7:0] keep_r;
  logic [7:0] rdata_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_r <= rst_seq_pkg::FLAGS_RST;
    end else if (clk_en) begin
      if (wr && addr == rst_seq_pkg::ADDR_FLAGS)
        flags_r <= wdata & rst_seq_pkg::FLAGS_MASK;
      // Hardware clear is placed last so it beats a same-cycle write
      if (por_s)
        flags_r[rst_seq_pkg::FLAG_POR_BIT] <= 1'b0;
      if (brownout_evt)
        flags_r[rst_seq_pkg::FLAG_BROWNOUT_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      trim_r <= rst_seq_pkg::TRIM_RST;
    else if (clk_en && wr && addr == rst_seq_pkg::ADDR_TRIM)
      trim_r <= wdata;
  end

  // No reset at all: content survives every reset kind
  always_ff @(posedge clk) begin
    if (clk_en && wr && addr == rst_seq_pkg::ADDR_KEEP)
      keep_r <= wdata;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      rdata_r <= 8'h00;
      if (rd) begin
        unique case (addr)
          rst_seq_pkg::ADDR_FLAGS: rdata_r <= flags_r;
          rst_seq_pkg::ADDR_CAUSE: rdata_r <= {5'h00, cause_r};
          rst_seq_pkg::ADDR_TRIM:  rdata_r <= trim_r;
          rst_seq_pkg::ADDR_KEEP:  rdata_r <= keep_r;
          default:                 rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign rdata    = rdata_r;
  assign osc_trim = trim_r;

  property p_pin_ignored;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && ext_reset_pin_cfg && state_r == rst_seq_pkg::ST_RUN &&
       $past(ext_reset_pin_cfg, 2)) |=> state_r != rst_seq_pkg::ST_PIN;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored)
    else $error("reset pin acted while ignored by config");

  property p_powerup_gate;
    @(posedge clk) disable iff (!rst_b)
      (state_r == rst_seq_pkg::ST_POWERUP &&
       $past(state_r) == rst_seq_pkg::ST_HOLD) |->
        !$past(powerup_timer_disable_cfg);
  endproperty
  a_powerup_gate: assert property (p_powerup_gate)
    else $error("power-up timer started while disabled");

  property p_startup_entry;
    @(posedge clk) disable iff (!rst_b)
      (state_r == rst_seq_pkg::ST_STARTUP &&
       $past(state_r) != rst_seq_pkg::ST_STARTUP) |->
        cnt_r == '0 && $past(cause_r) == rst_seq_pkg::CAUSE_POR;
  endproperty
  a_startup_entry: assert property (p_startup_entry)
    else $error("start-up count entered for wrong cause");

  property p_startup_len;
    @(posedge clk) disable iff (!rst_b)
      (state_r == rst_seq_pkg::ST_PIN &&
       $past(state_r) == rst_seq_pkg::ST_STARTUP) |->
        $past(cnt_r) == rst_seq_pkg::STARTUP_LAST;
  endproperty
  a_startup_len: assert property (p_startup_len)
    else $error("start-up count ended early");

  property p_powerup_len;
    @(posedge clk) disable iff (!rst_b)
      (state_r != rst_seq_pkg::ST_POWERUP &&
       state_r != rst_seq_pkg::ST_HOLD &&
       $past(state_r) == rst_seq_pkg::ST_POWERUP) |->
        $past(cnt_r) == rst_seq_pkg::POWERUP_LAST;
  endproperty
  a_powerup_len: assert property (p_powerup_len)
    else $error("power-up delay ended early");

  property p_dip_restart;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && !por_s && supply_low &&
       state_r == rst_seq_pkg::ST_POWERUP) |=>
        state_r == rst_seq_pkg::ST_HOLD &&
        cause_r == rst_seq_pkg::CAUSE_BROWNOUT;
  endproperty
  a_dip_restart: assert property (p_dip_restart)
    else $error("supply dip did not restart power-up delay");

  property p_por_flag;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && por_s) |=> !flags_r[rst_seq_pkg::FLAG_POR_BIT] &&
                            state_r == rst_seq_pkg::ST_HOLD;
  endproperty
  a_por_flag: assert property (p_por_flag)
    else $error("power-on did not clear its flag");

  property p_brownout_flag;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && brownout_evt) |=>
        !flags_r[rst_seq_pkg::FLAG_BROWNOUT_BIT];
  endproperty
  a_brownout_flag: assert property (p_brownout_flag)
    else $error("brown-out did not clear its flag");

  property p_clock_quarter_out;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && clock_quarter_out_mode) [*2] |-> shared_io_oe;
  endproperty
  a_clock_quarter_out: assert property (p_clock_quarter_out)
    else $error("clock-out mode left the shared pin undriven");

  property p_watchdog_pulse;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && state_r == rst_seq_pkg::ST_WATCHDOG && !por_s &&
       !brownout_evt) |=> !chip_reset;
  endproperty
  a_watchdog_pulse: assert property (p_watchdog_pulse)
    else $error("watchdog reset lasted more than one cycle");

  c_run:      cover property (@(posedge clk) disable iff (!rst_b)
                $fell(chip_reset));
  c_watchdog: cover property (@(posedge clk) disable iff (!rst_b)
                state_r == rst_seq_pkg::ST_WATCHDOG);
  c_wake:     cover property (@(posedge clk) disable iff (!rst_b)
                $rose(cpu_stall));
  c_dip:      cover property (@(posedge clk) disable iff (!rst_b)
                state_r == rst_seq_pkg::ST_POWERUP && supply_low);

endmodule : reset_startup_sequencer

// ===== verilog/rst_seq_pkg.sv
// Purpose: Shared constants and types of the reset and start-up sequencer
// Assumes: 100 MHz system clock; 8-bit register port
// Notes:   Timing counts are derived here from their printed figures
package rst_seq_pkg;

  localparam int CLK_MHZ            = 100;
  localparam int POWERUP_TIME_MS    = 72;
  // Internal RC ticks that span the nominal power-up time
  localparam int POWERUP_RC_TICKS   = 1024;
  localparam int STARTUP_OSC_CYCLES = 1024;
  localparam int EXT_RESET_MIN_NS   = 2000;
  localparam int EXT_RESET_FILT_CYC =
    (EXT_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int BROWNOUT_MIN_NS    = 100;
  localparam int BROWNOUT_FILT_CYC  =
    (BROWNOUT_MIN_NS * CLK_MHZ + 999) / 1000;

  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] POWERUP_LAST = CNT_W'(POWERUP_RC_TICKS - 1);
  localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_OSC_CYCLES - 1);

  localparam logic [7:0] ADDR_FLAGS = 8'h8e;
  localparam logic [7:0] ADDR_CAUSE = 8'h8f;
  localparam logic [7:0] ADDR_TRIM  = 8'h90;
  localparam logic [7:0] ADDR_KEEP  = 8'h91;

  localparam int         FLAG_BROWNOUT_BIT = 0;
  localparam int         FLAG_POR_BIT      = 1;
  localparam logic [7:0] FLAGS_RST         = 8'h00;
  localparam logic [7:0] FLAGS_MASK        = 8'h03;
  localparam logic [7:0] TRIM_RST          = 8'h80;

  localparam logic [2:0] CRYSTAL_LOWPOWER_MODE = 3'h0;
  localparam logic [2:0] CRYSTAL_MID_MODE      = 3'h1;
  localparam logic [2:0] CRYSTAL_FAST_MODE     = 3'h2;
  localparam logic [2:0] EXT_CLOCK_MODE        = 3'h3;
  localparam logic [2:0] INTERNAL_OSC_MODE_IO  = 3'h4;
  localparam logic [2:0] INTERNAL_OSC_MODE_CLK = 3'h5;
  localparam logic [2:0] RC_MODE_IO            = 3'h6;
  localparam logic [2:0] RC_MODE_CLK           = 3'h7;

  typedef enum logic [2:0] {
    CAUSE_POR, CAUSE_WATCHDOG_RUN, CAUSE_WATCHDOG_SLEEP,
    CAUSE_PIN_RUN, CAUSE_PIN_SLEEP, CAUSE_BROWNOUT
  } cause_t;

  typedef enum logic [2:0] {
    ST_HOLD, ST_POWERUP, ST_STARTUP, ST_PIN, ST_WATCHDOG, ST_RUN, ST_WAKE
  } seq_state_t;

endpackage : rst_seq_pkg
